// File: rtl/ltt_defs.vh
// constants for the transparent transmit framer
`ifndef LTT_DEFS_VH
`define LTT_DEFS_VH
// register offsets (byte addresses)
`define LTT_REG_CTRL 10'h000
`define LTT_REG_STAT 10'h004
`define LTT_REG_SEG0 10'h010
`define LTT_REG_BUF0 10'h100
// control field positions
`define LTT_CTRL_TXREQ 10
`define LTT_CTRL_TWOB 15
`define LTT_CTRL_RXEN 16
`define LTT_CTRL_TXEN 17
// segment descriptor fields
`define LTT_SEG_RDY 8
`define LTT_SEG_CNT_HI 4
// status field positions
`define LTT_STAT_DONE 0
`define LTT_STAT_LINK 1
`define LTT_STAT_BUSY 2
`define LTT_STAT_T1 3
`define LTT_STAT_PTR 4
`define LTT_STAT_VS 8
`define LTT_STAT_ACK 12
// reset values and the packet address byte
`define LTT_CTRL_RST 32'h0000_0000
`define LTT_TXEN_RST 1'b0
`define LTT_ADDR_BYTE 8'h01
// framing constants
`define LTT_FLAG 8'h7E
`define LTT_CRC_INIT 16'hFFFF
`define LTT_CRC_POLY 16'h8408
`define LTT_STUFF_RUN 3'h5
`define LTT_SEG_BYTES 5'h10
`endif

// File: rtl/ltt_transmit.v
// transparent transmit framer with lookup segments and serial output
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
// Notes on behaviour
// - transparent: send next segment when requested, ready
// - transparent: header bytes come from buffer
// - count excludes header in packet mode
// - retransmission timer off during transparent frame
// - transparent end: done flag, clear request
// - link down packet: advance pointers, segment
// - link coming up clears pointer and sequence
// - two-byte select honoured only when transparent
// - two-byte select sends exactly two bytes
// - control bits 17 and 16 enable modes
`include "ltt_defs.vh"
module ltt_transmit (
	input wire sys_clk,
	input wire rstn,
	input wire [9:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire link_up,
	input wire [3:0] ack_pointer,
	input wire tx_clk,
	output reg tx_data,
	output reg t1_enable,
	output reg transparent_rx_enable,
	output reg tx_done_pulse
);
	////////////////////////////////////////////////////////////////
	// state codes, one-hot
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_OPEN = 5'b00010;
	localparam [4:0] ST_DATA = 5'b00100;
	localparam [4:0] ST_FCS = 5'b01000;
	localparam [4:0] ST_CLOSE = 5'b10000;

	// control bits
	reg transparent_tx_enable; // transparent transmit mode
	reg two_byte_frame_select; // two-byte transparent frame
	reg transmit_request; // host asks for a frame
	reg transmit_done_flag; // sticky end-of-frame flag
	// lookup segments: ready flag and byte count
	reg [3:0] buffer_ready_flag;
	reg [4:0] seg_count [0:3];
	// frame buffer, sixteen bytes per segment
	reg [7:0] buf_mem [0:63];
	// pointers
	reg [1:0] next_tx_pointer; // current lookup segment
	reg [3:0] send_seq; // send sequence variable
	// link clock synchroniser and edge finder
	reg tx_clk_s1;
	reg tx_clk_s2;
	reg tx_clk_d;
	reg bit_en;
	// link level synchroniser
	reg link_d;
	// serialiser state
	reg [4:0] state;
	reg [7:0] sh; // bits still to send, lsb first
	reg [2:0] bitn; // bit within byte
	reg [2:0] ones; // run of ones for zero insertion
	reg [15:0] crc; // running check sequence
	reg [4:0] byte_idx; // next frame byte
	reg [4:0] frame_len; // bytes in this frame
	reg frame_trans; // frame is transparent
	reg fcs_hi; // second check byte pending
	reg frame_end; // one-cycle end of frame
	integer i;

	////////////////////////////////////////////////////////////////
	// one crc step, reflected polynomial
	function [15:0] crc_step;
		input [15:0] c;
		input b;
		begin
			if (c[0] ^ b) begin
				crc_step = (c >> 1) ^ `LTT_CRC_POLY;
			end else begin
				crc_step = c >> 1;
			end
		end
	endfunction

	// frame byte at index k of the current segment
	function [7:0] frame_byte;
		input trans;
		input [4:0] k;
		reg [5:0] base;
		begin
			base = {next_tx_pointer, 4'h0};
			if (trans) begin
				frame_byte = buf_mem[base + {1'b0, k}];
			end else if (k == 5'h00) begin
				frame_byte = `LTT_ADDR_BYTE;
			end else if (k == 5'h01) begin
				frame_byte = {4'h0, send_seq[2:0], 1'b0};
			end else begin
				frame_byte = buf_mem[base + {1'b0, k} - 6'h02];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// start conditions
	wire seg_ready = buffer_ready_flag[next_tx_pointer];
	// check value after the bit now leaving the shifter
	wire [15:0] crc_next = crc_step(crc, sh[0]);
	wire start_trans = transmit_request & transparent_tx_enable & seg_ready;
	// packet start on a down link
	wire start_pkt = transmit_request & ~transparent_tx_enable & ~link_d & seg_ready;
	wire start_any = (state == ST_IDLE) & bit_en & (start_trans | start_pkt);
	// frame length for this start
	reg [4:0] next_len;
	always @* begin
		next_len = seg_count[next_tx_pointer];
		if (transparent_tx_enable) begin
			if (two_byte_frame_select) begin
				next_len = 5'h02;
			end
		end else begin
			next_len = seg_count[next_tx_pointer] + 5'h02;
		end
	end

	////////////////////////////////////////////////////////////////
	// link clock synchroniser, falling edge gives the bit enable
	always @(posedge sys_clk) begin
		if (!rstn) begin
			tx_clk_s1 <= 1'b0;
			tx_clk_s2 <= 1'b0;
			tx_clk_d <= 1'b0;
			bit_en <= 1'b0;
		end else begin
			tx_clk_s1 <= tx_clk;
			tx_clk_s2 <= tx_clk_s1;
			tx_clk_d <= tx_clk_s2;
			bit_en <= tx_clk_d & ~tx_clk_s2;
		end
	end

	////////////////////////////////////////////////////////////////
	// serialiser: flags, zero insertion, check sequence
	always @(posedge sys_clk) begin
		if (!rstn) begin
			state <= ST_IDLE;
			sh <= 8'h00;
			bitn <= 3'h0;
			ones <= 3'h0;
			crc <= `LTT_CRC_INIT;
			byte_idx <= 5'h00;
			frame_len <= 5'h00;
			frame_trans <= 1'b0;
			fcs_hi <= 1'b0;
			frame_end <= 1'b0;
			tx_data <= 1'b1;
		end else begin
			frame_end <= 1'b0;
			if (bit_en) begin
				case (state)
				ST_IDLE: begin
					// idle fill of ones between frames
					tx_data <= 1'b1;
					if (start_any) begin
						state <= ST_OPEN;
						sh <= `LTT_FLAG;
						bitn <= 3'h0;
						frame_len <= next_len;
						frame_trans <= transparent_tx_enable;
					end
				end
				ST_OPEN: begin
					// opening flag, no insertion
					tx_data <= sh[0];
					sh <= sh >> 1;
					bitn <= bitn + 3'h1;
					if (bitn == 3'h7) begin
						state <= ST_DATA;
						sh <= frame_byte(frame_trans, 5'h00);
						byte_idx <= 5'h01;
						ones <= 3'h0;
						crc <= `LTT_CRC_INIT;
					end
				end
				ST_DATA, ST_FCS: begin
					if (ones == `LTT_STUFF_RUN) begin
						// inserted zero, data bit waits
						tx_data <= 1'b0;
						ones <= 3'h0;
					end else begin
						tx_data <= sh[0];
						sh <= sh >> 1;
						ones <= sh[0] ? ones + 3'h1 : 3'h0;
						bitn <= bitn + 3'h1;
						if (state == ST_DATA) begin
							crc <= crc_next;
						end
						if (bitn == 3'h7) begin
							if (state == ST_DATA && byte_idx < frame_len) begin
								sh <= frame_byte(frame_trans, byte_idx);
								byte_idx <= byte_idx + 5'h01;
							end else if (state == ST_DATA) begin
								// last data bit folds into the check value
								state <= ST_FCS;
								sh <= ~crc_next[7:0];
								crc <= ~crc_next;
								fcs_hi <= 1'b1;
							end else if (fcs_hi) begin
								sh <= crc[15:8];
								fcs_hi <= 1'b0;
							end else begin
								state <= ST_CLOSE;
								sh <= `LTT_FLAG;
							end
						end
					end
				end
				ST_CLOSE: begin
					if (ones == `LTT_STUFF_RUN) begin
						// zero owed from the check sequence
						tx_data <= 1'b0;
						ones <= 3'h0;
					end else begin
						tx_data <= sh[0];
						sh <= sh >> 1;
						ones <= 3'h0;
						bitn <= bitn + 3'h1;
						if (bitn == 3'h7) begin
							state <= ST_IDLE;
							frame_end <= 1'b1;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// control, segments, pointers and end-of-frame actions
	always @(posedge sys_clk) begin
		if (!rstn) begin
			transparent_tx_enable <= `LTT_TXEN_RST;
			transparent_rx_enable <= 1'b0;
			two_byte_frame_select <= 1'b0;
			transmit_request <= 1'b0;
			transmit_done_flag <= 1'b0;
			buffer_ready_flag <= 4'h0;
			next_tx_pointer <= 2'h0;
			send_seq <= 4'h0;
			link_d <= 1'b0;
			t1_enable <= 1'b1;
			tx_done_pulse <= 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				seg_count[i] <= 5'h00;
			end
		end else begin
			link_d <= link_up;
			tx_done_pulse <= frame_end;
			// timer held off in transparent frame
			t1_enable <= ~(state != ST_IDLE && frame_trans) & ~start_trans;
			// host clears done by writing one to it
			if (reg_wr && reg_addr == `LTT_REG_STAT && reg_wdata[`LTT_STAT_DONE]) begin
				transmit_done_flag <= 1'b0;
			end
			if (frame_end) begin
				transmit_done_flag <= 1'b1;
				if (frame_trans) begin
					// request cleared, ready and pointer kept
					transmit_request <= 1'b0;
				end else begin
					next_tx_pointer <= next_tx_pointer + 2'h1;
					send_seq <= send_seq + 4'h1;
				end
			end
			// link coming up clears pointer and sequence
			if (link_up && !link_d) begin
				next_tx_pointer <= 2'h0;
				send_seq <= 4'h0;
			end
			// host writes come last so a new request wins over the clear
			if (reg_wr && reg_addr == `LTT_REG_CTRL) begin
				// mode enables at bits 17 and 16
				transparent_tx_enable <= reg_wdata[`LTT_CTRL_TXEN];
				transparent_rx_enable <= reg_wdata[`LTT_CTRL_RXEN];
				two_byte_frame_select <= reg_wdata[`LTT_CTRL_TWOB];
				transmit_request <= reg_wdata[`LTT_CTRL_TXREQ];
			end
			// segment descriptors
			for (i = 0; i < 4; i = i + 1) begin
				if (reg_wr && reg_addr == (`LTT_REG_SEG0 | {6'h00, i[1:0], 2'b00})) begin
					buffer_ready_flag[i] <= reg_wdata[`LTT_SEG_RDY];
					seg_count[i] <= reg_wdata[`LTT_SEG_CNT_HI:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// frame buffer writes, one byte per word
	always @(posedge sys_clk) begin
		if (reg_wr && reg_addr[9:8] == 2'h1) begin
			buf_mem[reg_addr[7:2]] <= reg_wdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe, zero elsewhere
	always @(posedge sys_clk) begin
		if (!rstn) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= 32'h0000_0000;
			if (reg_rd) begin
				if (reg_addr == `LTT_REG_CTRL) begin
					reg_rdata[`LTT_CTRL_TXEN] <= transparent_tx_enable;
					reg_rdata[`LTT_CTRL_RXEN] <= transparent_rx_enable;
					reg_rdata[`LTT_CTRL_TWOB] <= two_byte_frame_select;
					reg_rdata[`LTT_CTRL_TXREQ] <= transmit_request;
				end else if (reg_addr == `LTT_REG_STAT) begin
					reg_rdata[`LTT_STAT_DONE] <= transmit_done_flag;
					reg_rdata[`LTT_STAT_LINK] <= link_d;
					reg_rdata[`LTT_STAT_BUSY] <= (state != ST_IDLE);
					reg_rdata[`LTT_STAT_T1] <= t1_enable;
					reg_rdata[`LTT_STAT_PTR + 1:`LTT_STAT_PTR] <= next_tx_pointer;
					reg_rdata[`LTT_STAT_VS + 3:`LTT_STAT_VS] <= send_seq;
					// host compares these before transparent use
					reg_rdata[`LTT_STAT_ACK + 3:`LTT_STAT_ACK] <= ack_pointer;
				end else if (reg_addr[9:4] == 6'h01 && reg_addr[1:0] == 2'h0) begin
					reg_rdata[`LTT_SEG_RDY] <= buffer_ready_flag[reg_addr[3:2]];
					reg_rdata[`LTT_SEG_CNT_HI:0] <= seg_count[reg_addr[3:2]];
				end else if (reg_addr[9:8] == 2'h1) begin
					reg_rdata[7:0] <= buf_mem[reg_addr[7:2]];
				end
			end
		end
	end
endmodule

// File: verification/ltt_checker.sv
// port checker for the transparent transmit framer
`timescale 1ns/10ps
`include "ltt_defs.vh"
module ltt_checker (
	input wire sys_clk,
	input wire rstn,
	input wire [9:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire link_up,
	input wire [3:0] ack_pointer,
	input wire tx_clk,
	input wire tx_data,
	input wire t1_enable,
	input wire transparent_rx_enable,
	input wire tx_done_pulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// status read while the link inputs are steady
	sequence s_stat_rd;
		reg_rd && reg_addr == `LTT_REG_STAT && $stable(link_up) && $stable(ack_pointer);
	endsequence
	// a control write one or two cycles back
	sequence s_ctrl_wr;
		$past(reg_wr && reg_addr == `LTT_REG_CTRL) || $past(reg_wr && reg_addr == `LTT_REG_CTRL, 2);
	endsequence
	property p_rd_zero;
		!$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside read slot");
	property p_unmapped;
		$past(reg_rd && reg_addr == 10'h3fc) |-> reg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_done_one;
		tx_done_pulse |=> !tx_done_pulse;
	endproperty
	a_done_one: assert property (p_done_one) else $error("done pulse too long");
	property p_data_low;
		$changed(tx_data) |-> !tx_clk;
	endproperty
	a_data_low: assert property (p_data_low) else $error("serial data moved on high clock");
	property p_rx_mirror;
		$changed(transparent_rx_enable) |-> s_ctrl_wr;
	endproperty
	a_rx_mirror: assert property (p_rx_mirror) else $error("rx enable moved without write");
	property p_link;
		s_stat_rd |=> reg_rdata[1] == $past(link_up);
	endproperty
	a_link: assert property (p_link) else $error("status link bit wrong");
	property p_ack;
		s_stat_rd |=> reg_rdata[15:12] == $past(ack_pointer);
	endproperty
	a_ack: assert property (p_ack) else $error("status ack field wrong");
	property p_t1_hold;
		$fell(t1_enable) |=> !t1_enable [*8];
	endproperty
	a_t1_hold: assert property (p_t1_hold) else $error("timer enable back too soon");
endmodule
bind ltt_transmit ltt_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
	.ack_pointer(ack_pointer), .tx_clk(tx_clk), .tx_data(tx_data), .t1_enable(t1_enable),
	.transparent_rx_enable(transparent_rx_enable), .tx_done_pulse(tx_done_pulse));

// File: verification/ltt_remote.sv
// remote station model: link clock and frame receiver
`timescale 1ns/10ps
module ltt_remote (
	input wire stall,
	input wire tx_data,
	output logic tx_clk,
	output int frames,
	output int nbytes,
	output logic fcs_ok,
	output logic [7:0] rxb [0:31]
);
	bit q[$];
	int ones, i;
	logic [15:0] c;
	// 160 ns link clock, held while stalled to act slowly
	initial begin
		tx_clk = 1;
		frames = 0;
		nbytes = 0;
		fcs_ok = 0;
		ones = 8;
		#37;
		forever begin
			#80;
			if (!stall) tx_clk = ~tx_clk;
		end
	end
	// sample mid-bit, drop stuffed zeros, cut frames at flags
	always @(posedge tx_clk) begin
		if (ones == 5 && !tx_data) ones = 0;
		else begin
			q.push_back(tx_data);
			if (ones == 6 && !tx_data) begin
				if (q.size() > 24) begin
					nbytes = (q.size() - 8) / 8;
					c = 16'hffff;
					for (i = 0; i < nbytes * 8; i++) begin
						rxb[i / 8][i % 8] = q[i];
						c = (c >> 1) ^ ((c[0] ^ q[i]) ? 16'h8408 : 16'h0000);
					end
					fcs_ok = (c == 16'hf0b8);
					frames++;
				end
				q.delete();
			end
			ones = tx_data ? ones + 1 : 0;
			if (ones > 6) q.delete();
		end
	end
endmodule

// File: verification/tb_top.sv
// self-checking bench for the transparent transmit framer
`timescale 1ns/10ps
`include "ltt_defs.vh"
module tb_top;
	logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, link_up = 0, stall = 0;
	logic [9:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0;
	logic [3:0] ack_pointer = 0;
	wire [31:0] reg_rdata;
	wire tx_clk, tx_data, t1_enable, rx_en, done;
	int frames, nbytes, n_mismatch = 0, n_compared = 0, k, fr;
	logic fcs_ok, t1_low, d;
	logic [7:0] rxb [0:31];
	always #2.5 sys_clk = ~sys_clk;
	ltt_transmit DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up), .ack_pointer(ack_pointer),
		.tx_clk(tx_clk), .tx_data(tx_data), .t1_enable(t1_enable), .transparent_rx_enable(rx_en),
		.tx_done_pulse(done));
	ltt_remote link (.stall(stall), .tx_data(tx_data), .tx_clk(tx_clk), .frames(frames), .nbytes(nbytes),
		.fcs_ok(fcs_ok), .rxb(rxb));
	// buffer byte pattern, long runs of ones to force stuffing
	function automatic logic [7:0] pat(input int n);
		return {n[3:0], 4'hf};
	endfunction
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input logic [9:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [9:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 0;
		#1 chk($sformatf("reg %h", a), e, reg_rdata);
	endtask
	// wait for the done pulse, then check what the far side got
	task frame(input int n, input logic [7:0] b0, input logic [7:0] b1);
		fr = frames;
		t1_low = 0;
		d = 0;
		repeat (9000) if (!d) begin
			@(posedge sys_clk);
			#1 d = done;
			if (!t1_enable) t1_low = 1;
		end
		// the far side sees the closing flag's last bit only at its next clock rise
		repeat (40) @(posedge sys_clk);
		chk("done", 1, d);
		chk("frames", fr + 1, frames);
		chk("length", n, nbytes);
		chk("fcs", 1, fcs_ok);
		chk("byte0", b0, rxb[0]);
		chk("byte1", b1, rxb[1]);
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1;
		rd(`LTT_REG_CTRL, 32'h0000_0000);
		rd(`LTT_REG_STAT, 32'h0000_0008);
		rd(10'h3fc, 32'h0000_0000);
		for (k = 0; k < 16; k++) wr(`LTT_REG_BUF0 + 10'(4 * k), pat(k));
		wr(`LTT_REG_SEG0, 32'h0000_0105);
		wr(`LTT_REG_CTRL, 32'h0002_0400);
		frame(7, 8'h0f, 8'h1f);
		chk("t1 low", 1, t1_low);
		rd(`LTT_REG_CTRL, 32'h0002_0000);
		rd(`LTT_REG_STAT, 32'h0000_0009);
		@(posedge sys_clk);
		link_up <= 1;
		wr(`LTT_REG_STAT, 32'h0000_0001);
		wr(`LTT_REG_SEG0, 32'h0000_0005);
		wr(`LTT_REG_CTRL, 32'h0002_8400);
		fr = frames;
		repeat (3000) @(posedge sys_clk);
		#1 chk("held", fr, frames);
		chk("idle", 1, tx_data);
		stall <= 1;
		wr(`LTT_REG_SEG0, 32'h0000_0105);
		repeat (400) @(posedge sys_clk);
		stall <= 0;
		frame(4, 8'h0f, 8'h1f);
		link_up <= 0;
		wr(`LTT_REG_STAT, 32'h0000_0001);
		wr(`LTT_REG_SEG0, 32'h0000_0103);
		wr(`LTT_REG_CTRL, 32'h0000_8400);
		frame(7, 8'h01, 8'h00);
		chk("info", pat(0), rxb[2]);
		rd(`LTT_REG_STAT, 32'h0000_0119);
		@(posedge sys_clk);
		ack_pointer <= 4'h3;
		link_up <= 1;
		wr(`LTT_REG_STAT, 32'h0000_0001);
		rd(`LTT_REG_STAT, 32'h0000_300a);
		wr(`LTT_REG_CTRL, 32'h0001_0000);
		repeat (2) @(posedge sys_clk);
		#1 chk("rx enable", 1, rx_en);
		final_report;
	end
endmodule
